// [rtl/plc_map.vh]
`ifndef PLC_MAP_VH
`define PLC_MAP_VH

// register indices; the apb byte address is four times the index
`define PLC_IDX_PHY_CTRL 8'h19
`define PLC_IDX_TBT_CTRL 8'h1A
`define PLC_IDX_PHY_STAT 8'h10
`define PLC_IDX_IRQ_STAT 8'h20
`define PLC_IDX_IRQ_MASK 8'h21

// general control fields
`define PLC_LED_MODE_HI 6
`define PLC_LED_MODE_LO 5
`define PLC_STA_ADDR_HI 4
`define PLC_STA_ADDR_LO 0

// 10base-t control/status fields
`define PLC_TBT_FIXED0   15
`define PLC_TBT_SQ_HI    11
`define PLC_TBT_SQ_LO    9
`define PLC_TBT_LOOP_OFF 8
`define PLC_TBT_LP_OFF   7
`define PLC_TBT_FRC_LINK 6
`define PLC_TBT_POL_INV  5
`define PLC_TBT_POL_STAT 4
`define PLC_TBT_APOL_OFF 3
`define PLC_TBT_SIL_MSB  2
`define PLC_TBT_SQE_OFF  1
`define PLC_TBT_JAB_OFF  0
`define PLC_TBT_RESET    16'h0804
`define PLC_TBT_WMASK    16'h7FEF

// phy status fields
`define PLC_PST_POL  12
`define PLC_PST_DUP  2
`define PLC_PST_SPD  1
`define PLC_PST_LINK 0

// interrupt status / mask fields
`define PLC_IRQ_W    3
`define PLC_IRQ_POL  0
`define PLC_IRQ_LINK 1
`define PLC_IRQ_COL  2
`define PLC_IRQ_MASK_RESET 3'h0

// timing
`define PLC_CLK_NS        40
`define PLC_BLINK_HALF_NS 50000000
`define PLC_BLINK_CYC     (`PLC_BLINK_HALF_NS / `PLC_CLK_NS)
`define PLC_BLINK_W       21

`endif

// [rtl/plc_tick.v]
`timescale 1ns/1ps
`default_nettype none

module plc_tick #(
	parameter integer COUNT = 1250000,
	parameter integer W     = 21
) (
	input  wire         pclk,
	input  wire         presetn,
	input  wire         en,
	output reg          tick
);

	// terminal count kept as an integer first, then cut to the counter width on purpose
	localparam integer LAST_I = COUNT - 1;
	localparam [W-1:0] LAST   = LAST_I[W-1:0];

	reg [W-1:0] cnt_q;

	// counter restarts whenever enable drops so every burst starts on a full phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= {W{1'b0}};
			tick  <= 1'b0;
		end else if (!en) begin
			cnt_q <= {W{1'b0}};
			tick  <= 1'b0;
		end else if (cnt_q == LAST) begin
			cnt_q <= {W{1'b0}};
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
			tick  <= 1'b0;
		end
	end

endmodule // plc_tick

`default_nettype wire

// [rtl/plc_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "plc_map.vh"

module plc_top #(
	parameter integer BLINK_HALF = `PLC_BLINK_CYC
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        mgmt_bcast,
	input  wire        strap_led_mode0,
	input  wire [4:0]  strap_station_addr,
	input  wire        link_good,
	input  wire        activity,
	input  wire        collision,
	input  wire        speed_100,
	input  wire        full_duplex,
	input  wire        pol_inverted_det,
	input  wire        basic_ctrl_loopback,
	input  wire        mac_side_link_override,
	input  wire        sd_cfg_silence_lsb,
	output reg         link_indicator,
	output reg         speed_indicator,
	output reg         activity_indicator,
	output reg  [4:0]  station_address_field,
	output reg  [2:0]  squelch_level,
	output reg         ten_mb_loopback_off,
	output reg         link_pulse_tx_en,
	output reg         ten_mb_link_forced,
	output reg         ten_mb_polarity_invert,
	output reg         auto_polarity_fix_en,
	output reg  [1:0]  silence_threshold,
	output reg         sqe_test_en,
	output reg         long_transmit_guard_en,
	output reg         irq
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	reg  [1:0]             led_mode_select_q;
	reg  [4:0]             sta_addr_q;
	reg  [15:0]            tbt_q;
	reg                    pol_q;
	reg  [`PLC_IRQ_W-1:0]  irq_stat_q;
	reg  [`PLC_IRQ_W-1:0]  irq_mask_q;
	reg                    strap_done_q;
	reg                    blink_q;
	reg                    link_prev_q;
	reg                    col_prev_q;
	reg                    snap_pol_q;
	reg  [`PLC_IRQ_W-1:0]  snap_irq_q;

	reg  [31:0]            rd_val;
	reg  [`PLC_IRQ_W-1:0]  irq_stat_d;
	reg                    pol_d;
	reg                    link_ind_d;
	reg                    act_ind_d;

	wire        setup_ph = psel & ~penable;
	wire        done_ph  = psel & penable & pready;
	wire        wr_done  = done_ph & pwrite;
	wire        rd_done  = done_ph & ~pwrite;
	wire        in_page  = (paddr[11:10] == 2'h0);
	wire        hit_pcr  = in_page & (paddr[9:2] == `PLC_IDX_PHY_CTRL);
	wire        hit_tbt  = in_page & (paddr[9:2] == `PLC_IDX_TBT_CTRL);
	wire        hit_pst  = in_page & (paddr[9:2] == `PLC_IDX_PHY_STAT);
	wire        hit_ist  = in_page & (paddr[9:2] == `PLC_IDX_IRQ_STAT);
	wire        hit_imk  = in_page & (paddr[9:2] == `PLC_IDX_IRQ_MASK);
	wire        hit_any  = hit_pcr | hit_tbt | hit_pst | hit_ist | hit_imk;
	wire        link_eff = link_good | ten_mb_link_forced;
	wire        blink_tick;

	// ------------------------------------------------------------------
	// blink timer
	// ------------------------------------------------------------------
	// visible blink rate
	plc_tick #(
		.COUNT (BLINK_HALF),
		.W     (`PLC_BLINK_W)
	) u_blink (
		.pclk    (pclk),
		.presetn (presetn),
		.en      (activity),
		.tick    (blink_tick)
	);

	// ------------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------------
	always @* begin
		rd_val = 32'h0000_0000;
		if (hit_pcr) begin
			rd_val[`PLC_LED_MODE_HI:`PLC_LED_MODE_LO] = led_mode_select_q;
			rd_val[`PLC_STA_ADDR_HI:`PLC_STA_ADDR_LO] = sta_addr_q;
		end else if (hit_tbt) begin
			rd_val[15:0] = tbt_q;
			rd_val[`PLC_TBT_FIXED0] = 1'b0;
			rd_val[`PLC_TBT_POL_STAT] = pol_q;
		end else if (hit_pst) begin
			rd_val[`PLC_PST_POL]  = pol_q;
			rd_val[`PLC_PST_DUP]  = full_duplex;
			rd_val[`PLC_PST_SPD]  = ~speed_100;
			rd_val[`PLC_PST_LINK] = link_eff;
		end else if (hit_ist) begin
			rd_val[`PLC_IRQ_W-1:0] = irq_stat_q;
		end else if (hit_imk) begin
			rd_val[`PLC_IRQ_W-1:0] = irq_mask_q;
		end
	end

	// ------------------------------------------------------------------
	// apb slave: no wait states, data and error sampled at setup
	// ------------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			prdata     <= 32'h0000_0000;
			snap_pol_q <= 1'b0;
			snap_irq_q <= {`PLC_IRQ_W{1'b0}};
		end else begin
			pready <= setup_ph;
			if (setup_ph) begin
				pslverr <= ~hit_any;
				prdata  <= pwrite ? 32'h0000_0000 : rd_val;
				// only the bits software actually saw may be cleared later
				snap_pol_q <= ~pwrite & (hit_tbt | hit_pst) & pol_q;
				snap_irq_q <= (~pwrite & hit_ist) ? irq_stat_q : {`PLC_IRQ_W{1'b0}};
			end else if (done_ph) begin
				pslverr    <= 1'b0;
				snap_pol_q <= 1'b0;
				snap_irq_q <= {`PLC_IRQ_W{1'b0}};
			end
		end
	end

	// ------------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_done_q      <= 1'b0;
			led_mode_select_q <= 2'h0;
			sta_addr_q        <= 5'h00;
			tbt_q             <= `PLC_TBT_RESET;
			irq_mask_q        <= `PLC_IRQ_MASK_RESET;
		end else if (!strap_done_q) begin
			// straps are caught on the first edge after release, never under reset
			strap_done_q         <= 1'b1;
			led_mode_select_q[0] <= strap_led_mode0;
			sta_addr_q           <= strap_station_addr;
		end else if (wr_done) begin
			if (hit_pcr) begin
				led_mode_select_q <= pwdata[`PLC_LED_MODE_HI:`PLC_LED_MODE_LO];
				if (!mgmt_bcast) begin
					sta_addr_q <= pwdata[`PLC_STA_ADDR_HI:`PLC_STA_ADDR_LO];
				end
			end
			if (hit_tbt) begin
				tbt_q <= pwdata[15:0] & `PLC_TBT_WMASK;
			end
			if (hit_imk) begin
				irq_mask_q <= pwdata[`PLC_IRQ_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// polarity latch and interrupt status
	// ------------------------------------------------------------------
	always @* begin
		pol_d = pol_inverted_det | (pol_q & ~(rd_done & snap_pol_q));
		irq_stat_d = irq_stat_q & ~(rd_done ? snap_irq_q : {`PLC_IRQ_W{1'b0}});
		if (pol_inverted_det & ~pol_q) begin
			irq_stat_d[`PLC_IRQ_POL] = 1'b1;
		end
		if (link_eff != link_prev_q) begin
			irq_stat_d[`PLC_IRQ_LINK] = 1'b1;
		end
		if (collision & ~col_prev_q) begin
			irq_stat_d[`PLC_IRQ_COL] = 1'b1;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pol_q       <= 1'b0;
			irq_stat_q  <= {`PLC_IRQ_W{1'b0}};
			link_prev_q <= 1'b0;
			col_prev_q  <= 1'b0;
			irq         <= 1'b0;
		end else begin
			pol_q       <= pol_d;
			irq_stat_q  <= irq_stat_d;
			link_prev_q <= link_eff;
			col_prev_q  <= collision;
			irq         <= |(irq_stat_d & irq_mask_q);
		end
	end

	// ------------------------------------------------------------------
	// led indicators
	// ------------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_q <= 1'b0;
		end else if (!activity) begin
			blink_q <= 1'b0;
		end else if (blink_tick) begin
			blink_q <= ~blink_q;
		end
	end

	always @* begin
		link_ind_d = link_eff;
		act_ind_d  = 1'b0;
		if (led_mode_select_q[0]) begin
			link_ind_d = link_eff;
			act_ind_d  = activity;
		end else if (!led_mode_select_q[1]) begin
			link_ind_d = link_eff & ~(activity & blink_q);
			act_ind_d  = collision;
		end else begin
			link_ind_d = link_eff & ~(activity & blink_q);
			act_ind_d  = full_duplex;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_indicator     <= 1'b0;
			speed_indicator    <= 1'b0;
			activity_indicator <= 1'b0;
		end else begin
			link_indicator     <= link_ind_d;
			speed_indicator    <= speed_100;
			activity_indicator <= act_ind_d;
		end
	end

	// ------------------------------------------------------------------
	// control outputs towards the transceiver
	// ------------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			station_address_field  <= 5'h00;
			squelch_level          <= 3'h4;
			ten_mb_loopback_off    <= 1'b0;
			link_pulse_tx_en       <= 1'b1;
			ten_mb_link_forced     <= 1'b0;
			ten_mb_polarity_invert <= 1'b0;
			auto_polarity_fix_en   <= 1'b1;
			silence_threshold      <= 2'h2;
			sqe_test_en            <= 1'b0;
			long_transmit_guard_en <= 1'b0;
		end else begin
			station_address_field  <= sta_addr_q;
			squelch_level          <= tbt_q[`PLC_TBT_SQ_HI:`PLC_TBT_SQ_LO];
			ten_mb_loopback_off    <= tbt_q[`PLC_TBT_LOOP_OFF] | basic_ctrl_loopback;
			link_pulse_tx_en       <= ~tbt_q[`PLC_TBT_LP_OFF];
			ten_mb_link_forced     <= tbt_q[`PLC_TBT_FRC_LINK] | mac_side_link_override;
			ten_mb_polarity_invert <= tbt_q[`PLC_TBT_POL_INV];
			auto_polarity_fix_en   <= ~tbt_q[`PLC_TBT_APOL_OFF];
			silence_threshold      <= {tbt_q[`PLC_TBT_SIL_MSB], sd_cfg_silence_lsb};
			sqe_test_en            <= ~tbt_q[`PLC_TBT_SQE_OFF] & ~speed_100 & ~full_duplex;
			long_transmit_guard_en <= ~tbt_q[`PLC_TBT_JAB_OFF] & ~speed_100;
		end
	end

endmodule // plc_top

`default_nettype wire

// [test/plc_line_model.sv]
`timescale 1ns/1ps
`default_nettype none
// line-side status sources; each level changes only just after a clock edge
module plc_line_model (
	input  wire logic       pclk,
	input  wire logic [5:0] cond,
	output logic            link_good,
	output logic            activity,
	output logic            collision,
	output logic            speed_100,
	output logic            full_duplex,
	output logic            pol_inverted_det
);
	always @(posedge pclk) begin
		{pol_inverted_det, full_duplex, speed_100, collision, activity, link_good} <= cond;
	end
endmodule // plc_line_model
`default_nettype wire

// [test/plc_top_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module plc_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        speed_100,
	input wire logic        full_duplex,
	input wire logic        basic_ctrl_loopback,
	input wire logic        mac_side_link_override,
	input wire logic        sd_cfg_silence_lsb,
	input wire logic        speed_indicator,
	input wire logic [2:0]  squelch_level,
	input wire logic        ten_mb_loopback_off,
	input wire logic        ten_mb_link_forced,
	input wire logic [1:0]  silence_threshold,
	input wire logic        sqe_test_en,
	input wire logic        long_transmit_guard_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence tbt_rd;
		psel && !penable && !pwrite && paddr == 12'h068;
	endsequence
	spd_lamp_a: assert property (##1 speed_indicator == $past(speed_100))
		else $error("speed lamp wrong");
	loop_or_a: assert property (basic_ctrl_loopback |=> ten_mb_loopback_off)
		else $error("loopback off missing");
	link_or_a: assert property (mac_side_link_override |=> ten_mb_link_forced)
		else $error("forced link missing");
	sqe_gate_a: assert property ((speed_100 || full_duplex) |=> !sqe_test_en)
		else $error("heartbeat not gated");
	jab_gate_a: assert property (speed_100 |=> !long_transmit_guard_en)
		else $error("jabber not gated");
	sil_lsb_a: assert property ($changed(sd_cfg_silence_lsb) |=> silence_threshold[0] == $past(sd_cfg_silence_lsb))
		else $error("silence lsb wrong");
	top_zero_a: assert property (tbt_rd |=> !prdata[15])
		else $error("bit 15 read one");
	sq_reset_a: assert property ($rose(presetn) |-> squelch_level == 3'h4)
		else $error("squelch reset wrong");
endmodule // plc_chk
bind plc_top plc_chk u_chk (.*);
`default_nettype wire

// [test/plc_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
module plc_top_test;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mgmt_bcast = 0, err;
	logic        strap_led_mode0 = 1, basic_ctrl_loopback = 0, mac_side_link_override = 0, sd_cfg_silence_lsb = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	logic [4:0]  strap_station_addr = 5'h13;
	logic [5:0]  cond = 0;
	logic [8:0]  tab [0:3] = '{9'h1A5, 9'h127, 9'h135, 9'h127};
	wire  [31:0] prdata;
	wire         pready, pslverr, link_good, activity, collision, speed_100, full_duplex, pol_inverted_det;
	wire         link_indicator, speed_indicator, activity_indicator, ten_mb_loopback_off, link_pulse_tx_en, irq;
	wire         ten_mb_link_forced, ten_mb_polarity_invert, auto_polarity_fix_en, sqe_test_en, long_transmit_guard_en;
	wire  [4:0]  station_address_field;
	wire  [2:0]  squelch_level;
	wire  [1:0]  silence_threshold;
	wire  [11:0] ctl = {squelch_level, ten_mb_loopback_off, link_pulse_tx_en, ten_mb_link_forced,
		ten_mb_polarity_invert, auto_polarity_fix_en, silence_threshold, sqe_test_en, long_transmit_guard_en};
	int          n_fail = 0, n_tests = 0;
	always #20 pclk = ~pclk;
	plc_line_model u_line (.pclk, .cond, .link_good, .activity, .collision, .speed_100, .full_duplex, .pol_inverted_det);
	plc_top #(.BLINK_HALF(8)) u_dut (.*);
	task report_and_stop;
		if (n_fail == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// setup edge, then access until pready is sampled high
	task xfer(input w, input [11:0] a, input [15:0] d);
		int i;
		i = 0;
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			i++;
			if (i > 20) begin
				n_fail++;
				report_and_stop;
			end
			@(posedge pclk);
		end
		rd = prdata; err = pslverr;
		psel <= 0; penable <= 0;
	endtask
	task idle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task pol_pulse;
		cond <= 6'h20; idle(1); cond <= 6'h00; idle(4);
	endtask
	task wait_link(input v);
		int i;
		i = 0;
		while (link_indicator !== v) begin
			i++;
			if (i > 40) begin
				n_fail++;
				report_and_stop;
			end
			@(posedge pclk);
		end
	endtask
	initial begin
		idle(10);
		presetn <= 1;
		idle(2);
		xfer(0, 12'h064, 0); chk(rd, 32'h33); chk(station_address_field, 32'h13);
		xfer(0, 12'h068, 0); chk(rd, 32'h0804);
		mgmt_bcast <= 1; xfer(1, 12'h064, 16'h000A); mgmt_bcast <= 0;
		xfer(0, 12'h064, 0); chk(rd, 32'h13);
		xfer(1, 12'h064, 16'h000A); xfer(0, 12'h064, 0); chk(station_address_field, 32'h0A);
		xfer(1, 12'h068, 16'hFFFF); xfer(0, 12'h068, 0); chk(rd, 32'h7FEF); chk(ctl, 32'hF68);
		basic_ctrl_loopback <= 1; mac_side_link_override <= 1; sd_cfg_silence_lsb <= 1;
		xfer(1, 12'h068, 0); idle(2); chk(ctl, 32'h1D7);
		cond <= 6'h08; idle(3); chk(ctl, 32'h1D4);
		cond <= 6'h10; idle(3); chk(ctl, 32'h1D5);
		cond <= 0; mac_side_link_override <= 0; basic_ctrl_loopback <= 0;
		pol_pulse; xfer(0, 12'h068, 0); chk(rd, 32'h10);
		xfer(0, 12'h040, 0); chk(rd, 32'h2);
		xfer(0, 12'h080, 0); xfer(1, 12'h084, 16'h0007);
		pol_pulse; chk(irq, 1);
		xfer(0, 12'h080, 0); chk(rd, 32'h1); idle(2); chk(irq, 0);
		xfer(1, 12'h084, 0); pol_pulse; chk(irq, 0);
		xfer(0, 12'h0FC, 0); chk(err, 1); chk(rd, 0);
		// lamps per mode for link+collision, link+duplex, link+activity+speed
		for (int m = 0; m < 4; m++) begin
			cond <= 0;
			xfer(1, 12'h064, {9'h000, m[1:0], 5'h0A});
			cond <= 6'h05; idle(3); chk({link_indicator, activity_indicator, speed_indicator}, tab[m][8:6]);
			cond <= 6'h11; idle(3); chk({link_indicator, activity_indicator, speed_indicator}, tab[m][5:3]);
			cond <= 6'h0B; idle(3); chk({link_indicator, activity_indicator, speed_indicator}, tab[m][2:0]);
		end
		cond <= 0;
		xfer(1, 12'h064, 16'h000A);
		cond <= 6'h03; idle(3);
		wait_link(0); chk(link_indicator, 0);
		wait_link(1); chk(link_indicator, 1);
		report_and_stop;
	end
endmodule // plc_top_test
`default_nettype wire
